// ==== irq_pkg.sv ====
// Package: shared constants and types for the interrupt request/acknowledge link
package irq_pkg;

  // ----------------------------------------------------------------------
  // Sizes and addresses
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_SRC      = 8;
  localparam int unsigned SRC_W        = 3;
  localparam int unsigned LVL_W        = 3;
  localparam int unsigned ADDR_W       = 16;
  localparam logic [15:0] ACK_ADDR     = 16'h0000;
  localparam logic [15:0] SP_RESET     = 16'h0000;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;

  // ----------------------------------------------------------------------
  // Control byte layout (one per source)
  // ----------------------------------------------------------------------
  localparam int unsigned LVL_LSB      = 0;
  localparam int unsigned PEND_BIT     = 3;
  localparam int unsigned POL_BIT      = 4;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PIN_MIN_NS    = 1000;
  localparam int unsigned PIN_MIN_CYC   = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILTER_TAPS   = 3;
  localparam int unsigned REENABLE_GAP  = 2;

  typedef logic [NUM_SRC-1:0] src_vec_t;

endpackage : irq_pkg

// ==== irq_link_if.sv ====
// Interface: CPU-side link between the interrupt controller and the CPU end
`timescale 1ns/100ps
interface irq_link_if;
  import irq_pkg::*;
  logic                 irq_req;
  logic [SRC_W-1:0]     irq_num;
  logic [LVL_W-1:0]     irq_lvl;
  logic                 rd_en;
  logic                 ack_cycle;
  logic [ADDR_W-1:0]    rd_addr;
  logic [7:0]           rd_data;
  logic                 wr_en;
  logic [SRC_W-1:0]     wr_sel;
  logic [7:0]           wr_data;
  logic                 wr_rmw;
  logic                 gie;
  logic [15:0]          stack_pointer;

  // Controller end
  modport ctrl (output irq_req, irq_num, irq_lvl, rd_data, stack_pointer,
                input rd_en, ack_cycle, rd_addr, wr_en, wr_sel, wr_data, wr_rmw, gie);
  // CPU end
  modport cpu  (input irq_req, irq_num, irq_lvl, rd_data, stack_pointer,
                output rd_en, ack_cycle, rd_addr, wr_en, wr_sel, wr_data, wr_rmw, gie);
endinterface : irq_link_if

// ==== irq_ctrl.sv ====
// Module: interrupt request flags, priority and acknowledge read at 00000h
`timescale 1ns/100ps
module irq_ctrl
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic          REF_CLK,
  input  wire logic          RST_N,
  // Source events and pins
  input  wire irq_pkg::src_vec_t SRC_EVENT,
  input  wire irq_pkg::src_vec_t SRC_PIN,
  input  wire logic          FILTER_CLK_EN,
  // CPU link
  irq_link_if.ctrl           link
);
  import irq_pkg::*;

  // ----------------------------------------------------------------------
  // Notes for users of this block
  // ----------------------------------------------------------------------
  // Any read at the acknowledge address clears the winning flag, so a
  // program read there silently cancels a request.
  // Stack pointer is a fixed reset value; the CPU end must load its own
  // copy before interrupts are enabled.
  // A control write that changes polarity raises the flag one cycle
  // later; software clears it with a plain write afterwards.
  // Level 0 keeps a flag out of arbitration, but the flag still records.
  // Pin levels shorter than the filter window are dropped, not stored.
  // A plain control write loses an event that lands in the same cycle;
  // software must not rewrite a byte while its source can fire.

  // ----------------------------------------------------------------------
  // Per-source and shared state
  // ----------------------------------------------------------------------
  logic [7:0]        ctrl_r   [NUM_SRC];
  src_vec_t          pend_r;
  src_vec_t          pin_flt_r;
  src_vec_t          pin_prev_r;
  src_vec_t          pol_prev_r;
  logic              ack_rd;
  logic              stray_rd;
  logic [1:0]        flt_cnt_r [NUM_SRC];
  logic [15:0]       sp_r;
  logic [7:0]        rd_data_r;
  src_vec_t          set_vec;
  src_vec_t          clr_vec;
  src_vec_t          en_vec;
  logic [SRC_W-1:0]  top_num;
  logic [LVL_W-1:0]  top_lvl;
  logic              top_any;
  logic              zero_rd;

  // Read of the acknowledge address, by sequence or by program
  assign zero_rd = link.rd_en && (link.rd_addr == ACK_ADDR);

  // Acknowledge sequence read versus a program read of the same address
  assign ack_rd   = zero_rd && link.ack_cycle;
  assign stray_rd = zero_rd && !link.ack_cycle;

  // ----------------------------------------------------------------------
  // Per-source flag logic
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      wire logic pol      = ctrl_r[g][POL_BIT];
      wire logic pin_act  = pin_flt_r[g] ^ pol;
      wire logic prev_act = pin_prev_r[g] ^ pol;
      wire logic wr_me    = link.wr_en && (link.wr_sel == SRC_W'(g));
      wire logic pol_chg  = pol ^ pol_prev_r[g];
      // Active pin edge, event pulse or a polarity rewrite sets the flag
      assign set_vec[g] = SRC_EVENT[g] | (pin_act & ~prev_act) | pol_chg;
      // Plain writes of pending=0 clear; read-modify-write leaves flag alone
      assign clr_vec[g] = (wr_me && !link.wr_rmw && !link.wr_data[PEND_BIT])
                        | ((ack_rd || stray_rd) && top_any
                           && top_num == SRC_W'(g));
      // Level field zero keeps the flag out of arbitration
      assign en_vec[g]  = pend_r[g] && (ctrl_r[g][LVL_LSB +: LVL_W] != '0);

      // Polarity of the previous cycle; a rewrite of it raises the flag
      // once, which software then clears with a plain write
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
          pol_prev_r[g] <= CTRL_RESET[POL_BIT];
        else
          pol_prev_r[g] <= pol;
      end

      // Digital filter: level accepted after three equal filter samples
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          flt_cnt_r[g] <= 2'h0;
          pin_flt_r[g] <= 1'b0;
        end
        else if (FILTER_CLK_EN)
        begin
          if (SRC_PIN[g] == pin_flt_r[g])
            flt_cnt_r[g] <= 2'h0;
          else if (flt_cnt_r[g] == 2'(FILTER_TAPS - 1))
          begin
            flt_cnt_r[g] <= 2'h0;
            pin_flt_r[g] <= SRC_PIN[g];
          end
          else
            flt_cnt_r[g] <= flt_cnt_r[g] + 2'h1;
        end
      end

      // Control byte: level and polarity; write lands one cycle after strobe
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
          ctrl_r[g] <= CTRL_RESET;
        else if (wr_me)
          ctrl_r[g] <= link.wr_data;
      end

      // Pending flag: a set in the same cycle as a clear wins, except that a
      // plain control write without rmw drops a coincident event
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
          pend_r[g] <= 1'b0;
        else if (set_vec[g] && !(wr_me && !link.wr_rmw))
          pend_r[g] <= 1'b1;
        else if (clr_vec[g])
          pend_r[g] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Priority: highest level wins, lower number breaks ties
  // ----------------------------------------------------------------------
  always_comb
  begin
    top_any = 1'b0;
    top_num = '0;
    top_lvl = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (en_vec[i] && (!top_any || ctrl_r[i][LVL_LSB +: LVL_W] > top_lvl))
      begin
        top_any = 1'b1;
        top_num = SRC_W'(i);
        top_lvl = ctrl_r[i][LVL_LSB +: LVL_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------------
  // Held at its reset value; the CPU end has no write path into it
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      sp_r <= SP_RESET;
    else
      sp_r <= sp_r;
  end

  // ----------------------------------------------------------------------
  // Filtered pin history for edge detection
  // ----------------------------------------------------------------------
  // Reset level matches the idle low pin, so no false edge follows reset
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      pin_prev_r <= '0;
    else
      pin_prev_r <= pin_flt_r;
  end

  // ----------------------------------------------------------------------
  // Acknowledge read data
  // ----------------------------------------------------------------------
  // Number and level captured at the read, held until the next read
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rd_data_r <= 8'h00;
    else if (zero_rd)
      rd_data_r <= {1'b0, top_lvl, 1'b0, top_num};
  end

  // ----------------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------------
  assign link.irq_req       = top_any;
  assign link.irq_num       = top_num;
  assign link.irq_lvl       = top_lvl;
  assign link.rd_data       = rd_data_r;
  assign link.stack_pointer = sp_r;

endmodule : irq_ctrl

// ==== irq_cpu_end.sv ====
// Module: CPU end that acknowledges requests and performs control writes
`timescale 1ns/100ps
module irq_cpu_end
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic          REF_CLK,
  input  wire logic          RST_N,
  // User requests
  input  wire logic          GIE_SET,
  input  wire logic          GIE_CLR,
  input  wire logic          CTRL_WR,
  input  wire logic [SRC_W-1:0] CTRL_SEL,
  input  wire logic [7:0]    CTRL_DATA,
  // Acknowledge results
  output logic               ACK_DONE,
  output logic [7:0]         ACK_INFO,
  output logic               GIE,
  // Controller link
  irq_link_if.cpu            link
);
  import irq_pkg::*;

  typedef enum logic [1:0] {S_IDLE = 2'b00, S_ACK = 2'b01, S_DONE = 2'b10} st_t;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  st_t        st_r, st_nxt;
  logic       gie_r;
  logic [1:0] gap_r;
  logic       ack_done_r;
  logic [7:0] ack_info_r;

  // Acknowledge only with interrupts enabled and nothing in flight
  always_comb
  begin
    case (st_r)
      S_IDLE:  st_nxt = (gie_r && link.irq_req && !CTRL_WR) ? S_ACK : S_IDLE;
      S_ACK:   st_nxt = S_DONE;
      S_DONE:  st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // Acknowledge read at zero, plain move writes for the control bytes
  assign link.rd_en     = (st_r == S_ACK);
  assign link.ack_cycle = (st_r == S_ACK);
  assign link.rd_addr   = ACK_ADDR;
  assign link.wr_en     = CTRL_WR && !gie_r;
  assign link.wr_sel    = CTRL_SEL;
  assign link.wr_data   = CTRL_DATA;
  assign link.wr_rmw    = 1'b0;
  assign link.gie       = gie_r;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_r       <= S_IDLE;
      gie_r      <= 1'b0;
      gap_r      <= 2'h0;
      ack_done_r <= 1'b0;
      ack_info_r <= 8'h00;
    end
    else
    begin
      st_r       <= st_nxt;
      ack_done_r <= (st_r == S_DONE);
      if (st_r == S_DONE)
        ack_info_r <= link.rd_data;
      // Re-enable held off for two cycles after a control write
      if (link.wr_en)
        gap_r <= 2'(REENABLE_GAP);
      else if (gap_r != 2'h0)
        gap_r <= gap_r - 2'h1;
      if (GIE_CLR || st_r == S_ACK)
        gie_r <= 1'b0;
      else if (GIE_SET && gap_r == 2'h0 && !link.wr_en)
        gie_r <= 1'b1;
    end
  end

  assign ACK_DONE = ack_done_r;
  assign ACK_INFO = ack_info_r;
  assign GIE      = gie_r;

endmodule : irq_cpu_end

// ==== irq_link_chk.sv ====
// Checker: timing relations on the controller to CPU end link
`timescale 1ns/100ps
module irq_link_chk
  import irq_pkg::*;
(
  // Clock and reset
  input wire logic                    REF_CLK,
  input wire logic                    RST_N,
  // Link signals
  input wire logic                    irq_req,
  input wire logic [irq_pkg::SRC_W-1:0] irq_num,
  input wire logic [irq_pkg::LVL_W-1:0] irq_lvl,
  input wire logic                    rd_en,
  input wire logic                    ack_cycle,
  input wire logic [irq_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [7:0]              rd_data,
  input wire logic                    wr_en,
  input wire logic [irq_pkg::SRC_W-1:0] wr_sel,
  input wire logic [7:0]              wr_data,
  input wire logic                    wr_rmw,
  input wire logic                    gie,
  input wire logic [15:0]             stack_pointer
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // ----------------------------------------------------------------------
  // Steps of a read at zero and of a write
  // ----------------------------------------------------------------------
  sequence s_ack_read; rd_en && rd_addr == ACK_ADDR && irq_req; endsequence
  sequence s_winner_gone; !irq_req || irq_num != $past(irq_num); endsequence
  sequence s_gie_off; !gie [*3]; endsequence

  property p_sp; stack_pointer == SP_RESET; endproperty
  a_sp: assert property (p_sp) else $error("stack pointer moved");
  property p_quiet; $rose(RST_N) |-> !irq_req && rd_data == 8'h00 && !gie; endproperty
  a_quiet: assert property (p_quiet) else $error("link busy after reset");
  property p_info;
    s_ack_read |=> rd_data == {1'b0, $past(irq_lvl), 1'b0, $past(irq_num)};
  endproperty
  a_info: assert property (p_info) else $error("wrong read data at zero");
  property p_clear; s_ack_read ##0 ack_cycle |=> s_winner_gone; endproperty
  a_clear: assert property (p_clear) else $error("acked flag kept");
  property p_stray; s_ack_read ##0 !ack_cycle |=> s_winner_gone; endproperty
  a_stray: assert property (p_stray) else $error("stray read kept flag");
  property p_lvl; irq_req |-> irq_lvl != 3'h0; endproperty
  a_lvl: assert property (p_lvl) else $error("request at level zero");
  property p_hold;
    irq_req && !rd_en && !wr_en |=> irq_req && irq_lvl >= $past(irq_lvl);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_plain;
    wr_en && !wr_rmw && !wr_data[PEND_BIT] && wr_sel == irq_num && irq_req
      |=> s_winner_gone;
  endproperty
  a_plain: assert property (p_plain) else $error("plain write kept flag");
  property p_gap; wr_en |-> s_gie_off; endproperty
  a_gap: assert property (p_gap) else $error("enable too soon");
  property p_take; $rose(ack_cycle) |-> $past(gie); endproperty
  a_take: assert property (p_take) else $error("ack with enable off");
endmodule : irq_link_chk

// ==== interrupt_request_acknowledge_tb.sv ====
// Testbench: controller and CPU end joined over the link
`timescale 1ns/100ps
module interrupt_request_acknowledge_tb;
  import irq_pkg::*;
  logic       ref_clk, rst_n, gie_set, gie_clr, ctrl_wr, filter_clk_en, ack_done, gie;
  logic [2:0] ctrl_sel;
  logic [7:0] ctrl_data, ack_info;
  src_vec_t   src_event, src_pin;
  int         fail_count, cmp_count;
  // Rows: source, level, expected acknowledge byte
  logic [13:0] rows [4] = '{{3'h0, 3'h1, 8'h10}, {3'h7, 3'h7, 8'h77},
                            {3'h3, 3'h4, 8'h43}, {3'h6, 3'h2, 8'h26}};

  irq_link_if link ();
  irq_ctrl u_irq_ctrl (.REF_CLK(ref_clk), .RST_N(rst_n), .SRC_EVENT(src_event),
    .SRC_PIN(src_pin), .FILTER_CLK_EN(filter_clk_en), .link(link));
  irq_cpu_end u_irq_cpu_end (.REF_CLK(ref_clk), .RST_N(rst_n), .GIE_SET(gie_set),
    .GIE_CLR(gie_clr), .CTRL_WR(ctrl_wr), .CTRL_SEL(ctrl_sel), .CTRL_DATA(ctrl_data),
    .ACK_DONE(ack_done), .ACK_INFO(ack_info), .GIE(gie), .link(link));
  irq_link_chk u_irq_link_chk (.REF_CLK(ref_clk), .RST_N(rst_n), .irq_req(link.irq_req),
    .irq_num(link.irq_num), .irq_lvl(link.irq_lvl), .rd_en(link.rd_en),
    .ack_cycle(link.ack_cycle), .rd_addr(link.rd_addr), .rd_data(link.rd_data),
    .wr_en(link.wr_en), .wr_sel(link.wr_sel), .wr_data(link.wr_data),
    .wr_rmw(link.wr_rmw), .gie(link.gie), .stack_pointer(link.stack_pointer));

  // Clock at 100 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // Plain control write with interrupts off, then room for the enable gap
  task automatic wr_ctrl(input logic [2:0] s, input logic [7:0] d);
    ctrl_wr <= 1'b1;
    ctrl_sel <= s;
    ctrl_data <= d;
    @(posedge ref_clk);
    ctrl_wr <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : wr_ctrl

  task automatic fire(input src_vec_t v);
    src_event <= v;
    @(posedge ref_clk);
    src_event <= '0;
    repeat (2) @(posedge ref_clk);
  endtask : fire

  // Enable interrupts and wait a bounded time for the acknowledge
  task automatic ack(input logic [7:0] exp);
    int n;
    gie_set <= 1'b1;
    @(posedge ref_clk);
    gie_set <= 1'b0;
    n = 0;
    while (ack_done !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("ack_done", ack_done, 1'b1);
    chk("ack_info", ack_info, exp);
    chk("gie", gie, 1'b0);
    @(posedge ref_clk);
  endtask : ack

  // Watchdog against a hang
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {gie_set, gie_clr, ctrl_wr, ctrl_sel, ctrl_data} = '0;
    src_event = '0;
    src_pin = '0;
    filter_clk_en = 1'b1;
    rst_n = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i])
    begin
      wr_ctrl(rows[i][13:11], {5'h00, rows[i][10:8]});
      fire(src_vec_t'(1) << rows[i][13:11]);
      ack(rows[i][7:0]);
      chk("req", link.irq_req, 1'b0);
    end
    // Three pending at once: highest level, lowest index on a tie
    wr_ctrl(3'h1, 8'h02);
    wr_ctrl(3'h3, 8'h05);
    wr_ctrl(3'h6, 8'h05);
    fire(8'h4A);
    ack(8'h53);
    ack(8'h56);
    ack(8'h21);
    // Plain write of zero to the pending bit drops the request
    wr_ctrl(3'h4, 8'h06);
    fire(8'h10);
    chk("req", link.irq_req, 1'b1);
    wr_ctrl(3'h4, 8'h06);
    chk("req", link.irq_req, 1'b0);
    // Pin pulse two cycles over minimum width in both levels
    wr_ctrl(3'h5, 8'h02);
    src_pin <= 8'h20;
    repeat (PIN_MIN_CYC + 2) @(posedge ref_clk);
    src_pin <= 8'h00;
    repeat (PIN_MIN_CYC + 2) @(posedge ref_clk);
    ack(8'h25);
    // Polarity rewrite raises the flag, a plain write then clears it
    wr_ctrl(3'h2, 8'h13);
    chk("req", link.irq_req, 1'b1);
    chk("num", link.irq_num, 3'h2);
    wr_ctrl(3'h2, 8'h13);
    chk("req", link.irq_req, 1'b0);
    // Reset in mid-run with a request pending
    wr_ctrl(3'h2, 8'h03);
    fire(8'h04);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("req", link.irq_req, 1'b0);
    chk("sp", link.stack_pointer, SP_RESET);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("ack_done", ack_done, 1'b0);
    report_and_stop();
  end
endmodule : interrupt_request_acknowledge_tb
